// File: seg_xlate_pkg.sv
/*
 Shared constants and carrier types for the segment translation block.
 Assumes a single processor clock domain; the memory-side partner acknowledges each word.
*/
`default_nettype none

package seg_xlate_pkg;

	////////////////////////////////////////////////////////////////////////////
	// reset values and reserved areas
	localparam logic [15:0] MSW_RESET = 16'hFFF0;
	localparam int MSW_PE_BIT = 0;
	localparam logic [19:0] RESET_FETCH = 20'hFFFF0;
	localparam logic [19:0] INIT_AREA_END = 20'hFFFFF;
	localparam logic [23:0] VEC_BASE_RESET = 24'h000000;
	localparam logic [15:0] VEC_LIMIT_RESET = 16'h03FF;
	localparam logic [15:0] REAL_SEG_LIMIT = 16'hFFFF;
	localparam logic [15:0] NMI_MIN_LIMIT = 16'h000F;
	localparam logic [15:0] NMI_MIN_SP = 16'h0005;

	////////////////////////////////////////////////////////////////////////////
	// exception numbers
	localparam logic [7:0] EXC_LIMIT = 8'h08;
	localparam logic [7:0] EXC_SEG_OVERRUN = 8'h0D;
	localparam logic [7:0] EXC_GENERAL = 8'h0D;
	localparam logic [7:0] EXC_NOT_PRESENT = 8'h0B;

	////////////////////////////////////////////////////////////////////////////
	// descriptor layout: byte offsets of its words, access-rights bit positions
	localparam logic [23:0] DESC_OFS_LIMIT = 24'h000000;
	localparam logic [23:0] DESC_OFS_BASE = 24'h000002;
	localparam logic [23:0] DESC_OFS_RIGHTS = 24'h000004;
	localparam int RIGHTS_PRESENT = 7;
	localparam int RIGHTS_SEGMENT = 4;
	localparam int RIGHTS_EXEC = 3;
	localparam int RIGHTS_EXPAND_DOWN = 2;
	localparam int RIGHTS_WRITE_READ = 1;
	localparam int RIGHTS_ACCESSED = 0;
	localparam logic [7:0] REAL_RIGHTS = 8'h93;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC} access_kind_t;

	typedef struct packed {
		logic [23:0] base;
		logic [15:0] limit;
		logic [7:0] rights;
	} seg_desc_t;

	typedef struct packed {
		logic [1:0] seg;
		logic [15:0] offset;
		access_kind_t kind;
		logic is_word;
		logic is_stack;
	} access_req_t;

endpackage

`default_nettype wire

// File: addr_former.sv
/*
 Physical address formation from a segment base and an offset.
 Assumes the base of a real-mode segment already holds the selector times sixteen.
*/
`timescale 1ns/1ns
`default_nettype none

module addr_former (
	input wire logic i_prot,
	input wire logic [23:0] i_base,
	input wire logic [15:0] i_offset,
	output logic [23:0] o_addr
);

	logic [19:0] real_sum;

	// real-mode sum wraps inside one megabyte; upper lines stay low
	assign real_sum = i_base[19:0] + {4'h0, i_offset};
	assign o_addr = i_prot ? (i_base + {8'h00, i_offset}) : {4'h0, real_sum};

endmodule

`default_nettype wire

// File: access_checker.sv
/*
 Attribute and limit check of one access against a cached descriptor.
 Assumes the descriptor cache is valid for the segment that is named.
*/
`timescale 1ns/1ns
`default_nettype none

module access_checker import seg_xlate_pkg::*; (
	input wire logic i_prot,
	input wire seg_desc_t i_desc,
	input wire access_req_t i_req,
	output logic o_fault,
	output logic [7:0] o_code
);

	logic [16:0] last_ofs;
	logic is_code;
	logic kind_bad;
	logic limit_bad;

	assign last_ofs = {1'b0, i_req.offset} + {16'h0000, i_req.is_word};
	assign is_code = i_desc.rights[RIGHTS_EXEC];

	always_comb begin
		kind_bad = 1'b0;
		case (i_req.kind)
			ACC_EXEC: kind_bad = !is_code;
			ACC_WRITE: kind_bad = is_code || !i_desc.rights[RIGHTS_WRITE_READ];
			default: kind_bad = is_code && !i_desc.rights[RIGHTS_WRITE_READ];
		endcase
		// expand-down data takes offsets above the limit only
		if (!is_code && i_desc.rights[RIGHTS_EXPAND_DOWN]) begin
			limit_bad = (i_req.offset <= i_desc.limit) || last_ofs[16];
		end else begin
			limit_bad = last_ofs > {1'b0, i_desc.limit};
		end
		if (!i_prot) begin
			o_fault = last_ofs[16];
			o_code = EXC_SEG_OVERRUN;
		end else if (!i_desc.rights[RIGHTS_PRESENT]) begin
			o_fault = 1'b1;
			o_code = EXC_NOT_PRESENT;
		end else begin
			o_fault = kind_bad || limit_bad || !i_desc.rights[RIGHTS_SEGMENT];
			o_code = EXC_GENERAL;
		end
	end

endmodule

`default_nettype wire

// File: segment_address_translation.sv
/*
 Segment address translation, descriptor loading and mode control.
 Assumes a memory partner that acknowledges each word and honours the lock,
 and an instruction sequencer that presents one request per cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module segment_address_translation import seg_xlate_pkg::*; #(
	parameter logic [23:0] PHYS_TOP = 24'hFFFFFF
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_sel_load,
	input wire logic [1:0] i_sel_seg,
	input wire logic [15:0] i_selector,
	input wire logic [23:0] i_table_base,
	input wire logic i_acc_valid,
	input wire access_req_t i_acc,
	input wire logic i_vec_valid,
	input wire logic [7:0] i_vec_num,
	input wire logic i_load_status_word_instr,
	input wire logic [15:0] i_status_data,
	input wire logic i_load_vector_table_instr,
	input wire logic [23:0] i_table_load_base,
	input wire logic [15:0] i_table_load_limit,
	input wire logic i_halt_instr,
	input wire logic i_stack_wrap_odd,
	input wire logic i_nmi,
	input wire logic [15:0] i_stack_pointer,
	input wire logic i_mem_ack,
	input wire logic [15:0] i_mem_rdata,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic o_mem_lock,
	output logic [23:0] o_mem_addr,
	output logic [15:0] o_mem_wdata,
	output logic o_busy,
	output logic o_addr_valid,
	output logic [23:0] o_phys_addr,
	output logic o_upper_byte_enable_n,
	output logic o_fault,
	output logic [7:0] o_fault_code,
	output logic o_restore_state,
	output logic o_vec_addr_valid,
	output logic [23:0] o_vec_addr,
	output logic o_halt_cycle,
	output logic o_halt_a1,
	output logic o_shutdown,
	output logic o_prot_mode,
	output logic [15:0] o_machine_status,
	output logic [19:0] o_code_fetch_pointer,
	output logic [23:0] o_vec_base,
	output logic [15:0] o_vec_limit
);

	typedef enum logic [2:0] {FS_IDLE, FS_LIMIT, FS_BASE, FS_RIGHTS, FS_MARK} fetch_state_t;
	fetch_state_t state;
	seg_desc_t cache [4];
	seg_desc_t staged;
	logic [1:0] fetch_seg;
	logic [23:0] desc_addr, formed;
	logic prot, acc_take, vec_take, chk_fault, range_fault, acc_fault;
	logic vec_fault, exc_event, shut_cond, nmi_exit;
	logic [7:0] chk_code, exc_code;
	logic [15:0] vec_last, exc_last, next_msw;

	default clocking cb_main @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	assign prot = o_machine_status[MSW_PE_BIT];
	// no new access while a descriptor is in flight or the core is shut down
	assign acc_take = i_acc_valid && !o_busy && !o_shutdown;
	assign vec_take = i_vec_valid && !o_busy && !o_shutdown;

	////////////////////////////////////////////////////////////////////////////
	// address formation and checks
	addr_former u_addr (
		.i_prot(prot),
		.i_base(cache[i_acc.seg].base),
		.i_offset(i_acc.offset),
		.o_addr(formed)
	);

	access_checker u_check (
		.i_prot(prot),
		.i_desc(cache[i_acc.seg]),
		.i_req(i_acc),
		.o_fault(chk_fault),
		.o_code(chk_code)
	);

	assign range_fault = prot && (formed > PHYS_TOP);
	assign acc_fault = chk_fault || range_fault;
	assign vec_last = {6'h00, i_vec_num, 2'b11};
	assign vec_fault = !prot && (vec_last > o_vec_limit);
	// an access fault takes precedence over a vector fault in the same cycle
	assign exc_event = (acc_take && acc_fault) || (vec_take && vec_fault);
	assign exc_code = (acc_take && acc_fault) ? (range_fault ? EXC_GENERAL : chk_code) : EXC_LIMIT;
	assign exc_last = {6'h00, exc_code, 2'b11};
	assign shut_cond = !prot && ((exc_event && (exc_code == EXC_LIMIT || exc_code == EXC_SEG_OVERRUN)
		&& exc_last > o_vec_limit) || i_stack_wrap_odd);
	assign nmi_exit = i_nmi && (o_vec_limit >= NMI_MIN_LIMIT) && (i_stack_pointer > NMI_MIN_SP);

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_addr_valid <= 1'b0;
			o_phys_addr <= 24'h000000;
			o_upper_byte_enable_n <= 1'b1;
			o_fault <= 1'b0;
			o_fault_code <= 8'h00;
			o_restore_state <= 1'b0;
		end else begin
			// a faulting access never reaches the bus
			o_addr_valid <= acc_take && !acc_fault;
			if (acc_take && !acc_fault) begin
				o_phys_addr <= formed;
				o_upper_byte_enable_n <= !(i_acc.is_word || formed[0]);
			end
			o_fault <= exc_event;
			if (exc_event) begin
				o_fault_code <= exc_code;
			end
			o_restore_state <= exc_event && !(acc_take && acc_fault && i_acc.is_stack);
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_vec_addr_valid <= 1'b0;
			o_vec_addr <= 24'h000000;
		end else begin
			o_vec_addr_valid <= vec_take && !vec_fault && !(acc_take && acc_fault);
			if (vec_take) begin
				o_vec_addr <= o_vec_base + {14'h0000, i_vec_num, 2'b00};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// descriptor fetch: three locked reads then a locked write of the rights word
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= FS_IDLE;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_lock <= 1'b0;
			o_mem_addr <= 24'h000000;
			o_mem_wdata <= 16'h0000;
			o_busy <= 1'b0;
			fetch_seg <= 2'b00;
			desc_addr <= 24'h000000;
			staged <= '0;
		end else begin
			case (state)
				FS_IDLE: begin
					if (i_sel_load && prot && !o_shutdown) begin
						desc_addr <= i_table_base + {8'h00, i_selector[15:3], 3'b000};
						o_mem_addr <= i_table_base + {8'h00, i_selector[15:3], 3'b000} + DESC_OFS_LIMIT;
						fetch_seg <= i_sel_seg;
						o_mem_req <= 1'b1;
						o_mem_we <= 1'b0;
						o_mem_lock <= 1'b1;
						o_busy <= 1'b1;
						state <= FS_LIMIT;
					end
				end
				FS_LIMIT: begin
					if (i_mem_ack) begin
						staged.limit <= i_mem_rdata;
						o_mem_addr <= desc_addr + DESC_OFS_BASE;
						state <= FS_BASE;
					end
				end
				FS_BASE: begin
					if (i_mem_ack) begin
						staged.base[15:0] <= i_mem_rdata;
						o_mem_addr <= desc_addr + DESC_OFS_RIGHTS;
						state <= FS_RIGHTS;
					end
				end
				FS_RIGHTS: begin
					if (i_mem_ack) begin
						staged.base[23:16] <= i_mem_rdata[7:0];
						staged.rights <= i_mem_rdata[15:8];
						// write back under the same lock so no master sees a half update
						o_mem_we <= 1'b1;
						o_mem_wdata <= i_mem_rdata | (16'h0001 << (8 + RIGHTS_ACCESSED));
						state <= FS_MARK;
					end
				end
				FS_MARK: begin
					if (i_mem_ack) begin
						o_mem_req <= 1'b0;
						o_mem_we <= 1'b0;
						o_mem_lock <= 1'b0;
						o_busy <= 1'b0;
						state <= FS_IDLE;
					end
				end
				default: begin
					state <= FS_IDLE;
					o_mem_req <= 1'b0;
					o_mem_lock <= 1'b0;
					o_busy <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// descriptor cache, one entry per segment register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 4; i++) begin
				cache[i] <= '{base: 24'h000000, limit: REAL_SEG_LIMIT, rights: REAL_RIGHTS};
			end
		end else if (state == FS_MARK && i_mem_ack) begin
			cache[fetch_seg] <= '{base: staged.base, limit: staged.limit,
				rights: staged.rights | (8'h01 << RIGHTS_ACCESSED)};
		end else if (state == FS_IDLE && i_sel_load && !prot && !o_shutdown) begin
			cache[i_sel_seg] <= '{base: {4'h0, i_selector, 4'h0}, limit: REAL_SEG_LIMIT,
				rights: REAL_RIGHTS};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// machine status and vector table
	always_comb begin
		next_msw = o_machine_status;
		if (i_load_status_word_instr) begin
			next_msw = i_status_data;
			next_msw[MSW_PE_BIT] = i_status_data[MSW_PE_BIT] || prot;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_machine_status <= MSW_RESET;
			o_prot_mode <= 1'b0;
			o_code_fetch_pointer <= RESET_FETCH;
		end else begin
			o_machine_status <= next_msw;
			o_prot_mode <= next_msw[MSW_PE_BIT];
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_vec_base <= VEC_BASE_RESET;
			o_vec_limit <= VEC_LIMIT_RESET;
		end else if (i_load_vector_table_instr) begin
			o_vec_base <= i_table_load_base;
			o_vec_limit <= i_table_load_limit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// halt and shutdown signalling
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_shutdown <= 1'b0;
			o_halt_cycle <= 1'b0;
			o_halt_a1 <= 1'b0;
		end else begin
			o_halt_cycle <= 1'b0;
			if (o_shutdown) begin
				if (nmi_exit) begin
					o_shutdown <= 1'b0;
				end
			end else if (shut_cond) begin
				o_shutdown <= 1'b1;
				o_halt_cycle <= 1'b1;
				o_halt_a1 <= 1'b0;
			end else if (i_halt_instr) begin
				o_halt_cycle <= 1'b1;
				o_halt_a1 <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_real_high_lines;
		o_addr_valid && !$past(prot) |-> o_phys_addr[23:20] == 4'h0;
	endproperty
	a_real_high_lines: assert property (p_real_high_lines) else $error("upper lines set");
	property p_real_base;
		i_sel_load && !prot && !o_shutdown && state == FS_IDLE
			|=> cache[$past(i_sel_seg)].base == {4'h0, $past(i_selector), 4'h0};
	endproperty
	a_real_base: assert property (p_real_base) else $error("real base wrong");
	property p_wrap_fault;
		acc_take && !prot && i_acc.is_word && i_acc.offset == 16'hFFFF
			|=> o_fault && o_fault_code == EXC_SEG_OVERRUN && !o_addr_valid;
	endproperty
	a_wrap_fault: assert property (p_wrap_fault) else $error("segment wrap not refused");
	property p_restore;
		acc_take && acc_fault |=> o_restore_state == !$past(i_acc.is_stack);
	endproperty
	a_restore: assert property (p_restore) else $error("restore flag wrong");
	property p_vec_limit;
		vec_take && !prot && vec_last > o_vec_limit && !(acc_take && acc_fault)
			|=> o_fault && o_fault_code == EXC_LIMIT && !o_vec_addr_valid;
	endproperty
	a_vec_limit: assert property (p_vec_limit) else $error("vector beyond limit taken");
	property p_odd_wrap_shutdown;
		i_stack_wrap_odd && !prot && !o_shutdown |=> o_shutdown && o_halt_cycle && !o_halt_a1;
	endproperty
	a_odd_wrap_shutdown: assert property (p_odd_wrap_shutdown)
		else $error("odd stack wrap did not shut down");
	property p_nmi_hold;
		o_shutdown && (o_vec_limit < NMI_MIN_LIMIT || i_stack_pointer <= NMI_MIN_SP) |=> o_shutdown;
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("shutdown left too early");
	property p_lock;
		o_mem_req |-> o_mem_lock && o_busy;
	endproperty
	a_lock: assert property (p_lock) else $error("descriptor cycle not locked");
	property p_mark;
		state == FS_RIGHTS && i_mem_ack |=> o_mem_we && o_mem_wdata[8 + RIGHTS_ACCESSED];
	endproperty
	a_mark: assert property (p_mark) else $error("accessed bit not written");
	property p_pe_sticky;
		o_prot_mode |=> o_prot_mode && o_machine_status[MSW_PE_BIT];
	endproperty
	a_pe_sticky: assert property (p_pe_sticky) else $error("protect bit cleared");
	property p_pe_set;
		i_load_status_word_instr && i_status_data[MSW_PE_BIT] |=> o_prot_mode;
	endproperty
	a_pe_set: assert property (p_pe_set) else $error("protect bit not set");
	c_fetch_done: cover property (state == FS_MARK && i_mem_ack);
	c_shutdown: cover property ($rose(o_shutdown));
	c_prot_entry: cover property ($rose(o_prot_mode));

endmodule

`default_nettype wire

// File: mem_partner.sv
/*
 Behavioural system memory for the descriptor fetch port.
 Assumes one word per acknowledge; the bench sets the descriptor image and wait count.
*/
`timescale 1ns/1ns
`default_nettype none

module mem_partner (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	input wire logic [2:0] i_delay,
	input wire logic [47:0] i_desc,
	output logic o_ack,
	output logic [15:0] o_rdata
);

	logic [2:0] wait_cnt;

	////////////////////////////////////////////////////////////////////////////
	// answer after i_delay idle cycles; only the low lines pick a word
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack <= 1'b0;
			wait_cnt <= 3'h0;
			o_rdata <= 16'hA5A5;
		end else if (i_req && !o_ack && wait_cnt == i_delay) begin
			o_ack <= 1'b1;
			wait_cnt <= 3'h0;
			o_rdata <= i_desc[i_addr[2:1] * 16 +: 16];
		end else begin
			o_ack <= 1'b0;
			wait_cnt <= (i_req && !o_ack) ? wait_cnt + 3'h1 : 3'h0;
			// invert the last word each cycle between answers
			o_rdata <= ~o_rdata;
		end
	end

endmodule

`default_nettype wire

// File: segment_address_translation_tb_top.sv
/*
 Self-checking bench for the segment translation block.
 Assumes the memory partner model and a 50 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module segment_address_translation_tb_top import seg_xlate_pkg::*;;

	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_sel_load, i_acc_valid, i_vec_valid, i_halt_instr, i_stack_wrap_odd, i_nmi;
	logic i_load_status_word_instr, i_load_vector_table_instr, i_mem_ack;
	logic [1:0] i_sel_seg;
	logic [7:0] i_vec_num, o_fault_code;
	logic [15:0] i_selector, i_status_data, i_table_load_limit, i_stack_pointer, i_mem_rdata;
	logic [23:0] i_table_base, i_table_load_base;
	access_req_t i_acc;
	logic o_mem_req, o_mem_we, o_mem_lock, o_busy, o_addr_valid, o_upper_byte_enable_n;
	logic o_fault, o_restore_state, o_vec_addr_valid, o_halt_cycle, o_halt_a1, o_shutdown;
	logic o_prot_mode;
	logic [23:0] o_mem_addr, o_phys_addr, o_vec_addr, o_vec_base;
	logic [15:0] o_mem_wdata, o_machine_status, o_vec_limit;
	logic [19:0] o_code_fetch_pointer;
	logic [2:0] delay = 3'h0;
	logic [47:0] desc = 48'h0;
	int mismatches = 0;
	int tests_run = 0;

	// smaller top so the physical-limit fault is reachable
	segment_address_translation #(.PHYS_TOP(24'h7FFFFF)) segment_address_translation_inst (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sel_load(i_sel_load),
		.i_sel_seg(i_sel_seg), .i_selector(i_selector), .i_table_base(i_table_base),
		.i_acc_valid(i_acc_valid), .i_acc(i_acc), .i_vec_valid(i_vec_valid),
		.i_vec_num(i_vec_num), .i_load_status_word_instr(i_load_status_word_instr),
		.i_status_data(i_status_data), .i_load_vector_table_instr(i_load_vector_table_instr),
		.i_table_load_base(i_table_load_base), .i_table_load_limit(i_table_load_limit),
		.i_halt_instr(i_halt_instr), .i_stack_wrap_odd(i_stack_wrap_odd), .i_nmi(i_nmi),
		.i_stack_pointer(i_stack_pointer), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
		.o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_lock(o_mem_lock),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_busy(o_busy),
		.o_addr_valid(o_addr_valid), .o_phys_addr(o_phys_addr),
		.o_upper_byte_enable_n(o_upper_byte_enable_n), .o_fault(o_fault),
		.o_fault_code(o_fault_code), .o_restore_state(o_restore_state),
		.o_vec_addr_valid(o_vec_addr_valid), .o_vec_addr(o_vec_addr),
		.o_halt_cycle(o_halt_cycle), .o_halt_a1(o_halt_a1), .o_shutdown(o_shutdown),
		.o_prot_mode(o_prot_mode), .o_machine_status(o_machine_status),
		.o_code_fetch_pointer(o_code_fetch_pointer), .o_vec_base(o_vec_base),
		.o_vec_limit(o_vec_limit)
	);

	mem_partner mem_partner_inst (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(o_mem_req), .i_addr(o_mem_addr),
		.i_delay(delay), .i_desc(desc), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata)
	);

	always #10 i_clock = ~i_clock;

	////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task conclude;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task sel_load(input logic [1:0] seg, input logic [15:0] sel);
		@(posedge i_clock);
		i_sel_load <= 1'b1;
		i_sel_seg <= seg;
		i_selector <= sel;
		@(posedge i_clock);
		i_sel_load <= 1'b0;
	endtask

	task access(input logic [1:0] seg, input logic [15:0] ofs, input access_kind_t kind,
		input logic word, input logic stk);
		@(posedge i_clock);
		i_acc_valid <= 1'b1;
		i_acc <= '{seg, ofs, kind, word, stk};
		@(posedge i_clock);
		i_acc_valid <= 1'b0;
		#1;
	endtask

	task vector(input logic [7:0] n);
		@(posedge i_clock);
		i_vec_valid <= 1'b1;
		i_vec_num <= n;
		@(posedge i_clock);
		i_vec_valid <= 1'b0;
		#1;
	endtask

	task status_load(input logic [15:0] v);
		@(posedge i_clock);
		i_load_status_word_instr <= 1'b1;
		i_status_data <= v;
		@(posedge i_clock);
		i_load_status_word_instr <= 1'b0;
		#1;
	endtask

	task wait_halt(input logic a1);
		#1;
		for (int k = 0; k < 4 && o_halt_cycle !== 1'b1; k++) begin
			@(posedge i_clock);
			#1;
		end
		check({o_halt_cycle, o_halt_a1}, {1'b1, a1});
	endtask

	task prot_load(input logic [1:0] seg, input logic [15:0] sel, input logic [47:0] d,
		input logic [2:0] dl);
		int words;
		words = 0;
		desc <= d;
		delay <= dl;
		i_table_base <= 24'h001000;
		sel_load(seg, sel);
		for (int k = 0; k < 40 && words < 4; k++) begin
			#1;
			if (o_mem_req === 1'b1)
				check(o_mem_lock, 1'b1);
			if (i_mem_ack === 1'b1) begin
				check(o_mem_addr, 24'h001000 + {sel[15:3], 3'h0} + (words == 3 ? 4 : words * 2));
				check(o_mem_we, words == 3);
				if (words == 3)
					check(o_mem_wdata, d[47:32] | 16'h0100);
				words++;
			end
			@(posedge i_clock);
		end
		#1;
		check({o_busy, o_mem_req, o_mem_lock}, 3'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_reset;
		check(o_machine_status, 16'hFFF0);
		check(o_prot_mode, 1'b0);
		check(o_vec_base, 24'h000000);
		check(o_vec_limit, 16'h03FF);
		check(o_code_fetch_pointer, 20'hFFFF0);
	endtask

	task t_real;
		sel_load(2'h0, 16'hF000);
		access(2'h0, 16'hFFF0, ACC_EXEC, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h0FFFF0});
		check(o_upper_byte_enable_n, 1'b1);
		sel_load(2'h1, 16'h1234);
		access(2'h1, 16'h0005, ACC_WRITE, 1'b1, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h012345});
		check(o_upper_byte_enable_n, 1'b0);
		sel_load(2'h2, 16'hFFFF);
		access(2'h2, 16'h0010, ACC_READ, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h000000});
		access(2'h2, 16'hFFFF, ACC_READ, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h00FFEF});
		access(2'h2, 16'hFFFF, ACC_READ, 1'b1, 1'b0);
		check({o_fault, o_fault_code, o_restore_state}, {1'b1, 8'h0D, 1'b1});
		access(2'h2, 16'hFFFF, ACC_WRITE, 1'b1, 1'b1);
		check({o_fault, o_restore_state}, 2'h2);
		vector(8'hFF);
		check({o_vec_addr_valid, o_vec_addr}, {1'b1, 24'h0003FC});
	endtask

	task t_shutdown;
		@(posedge i_clock);
		i_load_vector_table_instr <= 1'b1;
		i_table_load_base <= 24'h000000;
		i_table_load_limit <= 16'h000F;
		@(posedge i_clock);
		i_load_vector_table_instr <= 1'b0;
		#1;
		check(o_vec_limit, 16'h000F);
		vector(8'h04);
		check({o_fault, o_fault_code}, {1'b1, 8'h08});
		wait_halt(1'b0);
		#40;
		check(o_shutdown, 1'b1);
		access(2'h0, 16'h0000, ACC_READ, 1'b0, 1'b0);
		check(o_addr_valid, 1'b0);
		i_stack_pointer <= 16'h0005;
		i_nmi <= 1'b1;
		repeat (3) @(posedge i_clock);
		#1;
		check(o_shutdown, 1'b1);
		i_stack_pointer <= 16'h0006;
		repeat (2) @(posedge i_clock);
		i_nmi <= 1'b0;
		#1;
		check(o_shutdown, 1'b0);
		@(posedge i_clock);
		i_halt_instr <= 1'b1;
		@(posedge i_clock);
		i_halt_instr <= 1'b0;
		wait_halt(1'b1);
		@(posedge i_clock);
		i_stack_wrap_odd <= 1'b1;
		@(posedge i_clock);
		i_stack_wrap_odd <= 1'b0;
		wait_halt(1'b0);
		#40;
		check(o_shutdown, 1'b1);
	endtask

	task t_prot;
		status_load(16'h0001);
		check({o_prot_mode, o_machine_status[0]}, 2'h3);
		status_load(16'hFFF0);
		check({o_prot_mode, o_machine_status}, {1'b1, 16'hFFF1});
		prot_load(2'h0, 16'h0010, {8'h92, 24'h123456, 16'h00FF}, 3'h3);
		access(2'h0, 16'h0010, ACC_READ, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h123466});
		access(2'h0, 16'h00FF, ACC_WRITE, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h123555});
		access(2'h0, 16'h0100, ACC_READ, 1'b0, 1'b0);
		check({o_fault, o_addr_valid, o_fault_code}, {2'h2, 8'h0D});
		access(2'h0, 16'h0000, ACC_EXEC, 1'b0, 1'b0);
		check({o_fault, o_fault_code}, {1'b1, 8'h0D});
		prot_load(2'h1, 16'h0018, {8'h9A, 24'h7FFFF0, 16'hFFFF}, 3'h0);
		access(2'h1, 16'h000F, ACC_EXEC, 1'b0, 1'b0);
		check({o_addr_valid, o_phys_addr}, {1'b1, 24'h7FFFFF});
		access(2'h1, 16'h0010, ACC_READ, 1'b0, 1'b0);
		check({o_fault, o_addr_valid, o_fault_code}, {2'h2, 8'h0D});
		access(2'h1, 16'h0000, ACC_WRITE, 1'b0, 1'b0);
		check({o_fault, o_fault_code}, {1'b1, 8'h0D});
		prot_load(2'h2, 16'h0020, {8'h1A, 24'h000100, 16'hFFFF}, 3'h1);
		access(2'h2, 16'h0000, ACC_READ, 1'b0, 1'b0);
		check({o_fault, o_addr_valid, o_fault_code}, {2'h2, 8'h0B});
		// expand-down data segment: only offsets above the limit are legal
		prot_load(2'h3, 16'h0028, {8'h96, 24'h040000, 16'h00FF}, 3'h2);
		access(2'h3, 16'h00FF, ACC_READ, 1'b0, 1'b0);
		check({o_fault, o_addr_valid, o_fault_code}, {2'h2, 8'h0D});
		access(2'h3, 16'h0100, ACC_WRITE, 1'b1, 1'b0);
		check({o_addr_valid, o_phys_addr, o_upper_byte_enable_n}, {1'b1, 24'h040100, 1'b0});
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		{i_sel_load, i_acc_valid, i_vec_valid, i_halt_instr, i_stack_wrap_odd, i_nmi} = 6'h00;
		{i_load_status_word_instr, i_load_vector_table_instr, i_sel_seg} = 4'h0;
		{i_vec_num, i_selector, i_status_data, i_table_load_limit} = 56'h0;
		{i_table_base, i_table_load_base} = 48'h0;
		i_stack_pointer = 16'h0100;
		i_acc = '0;
		repeat (4) @(posedge i_clock);
		i_arst_n <= 1'b1;
		#1;
		t_reset();
		t_real();
		t_shutdown();
		// reset rather than NMI leaves shutdown here, so re-enter real mode cleanly
		i_arst_n = 1'b0;
		@(posedge i_clock);
		i_arst_n <= 1'b1;
		t_prot();
		conclude();
	end

	initial begin
		#(20 * 4000);
		mismatches++;
		conclude();
	end

endmodule

`default_nettype wire
